/* tb.sv */
// Self-checking testbench for the external address and data bus.
`timescale 1ns/10ps
module tb;
  import xbus_pkg::*;
  logic clk = 1'b0, sys_rst = 1'b1, chip_reset_n = 1'b1, hold_req = 1'b0;
  logic float_n = 1'b1, data_hold_en = 1'b1, sel = 1'b0, ce = 1'b1;
  xbus_req_s req = '0;
  logic [22:0] ext_addr_o, ext_addr_oe, addr_keep_oe, ext_addr_i;
  logic [15:0] ext_data_o, ext_data_oe, data_keep_oe, ext_data_i, rdata_r;
  logic hold_ack_r;
  int num_errors = 0, num_checks = 0, cycles = 0;
  always #25 clk = ~clk;
  xbus_top u_dut (.clk(clk), .sys_rst(sys_rst), .ce(ce), .req(req),
    .chip_reset_n(chip_reset_n), .hold_req(hold_req), .float_n(float_n),
    .data_hold_en(data_hold_en), .ext_addr_i(ext_addr_i), .ext_data_i(ext_data_i),
    .ext_addr_o(ext_addr_o), .ext_addr_oe(ext_addr_oe), .ext_data_o(ext_data_o),
    .ext_data_oe(ext_data_oe), .rdata_r(rdata_r), .hold_ack_r(hold_ack_r),
    .addr_keep_oe(addr_keep_oe), .data_keep_oe(data_keep_oe));
  xbus_mem_model u_mem (.clk(clk), .sel(sel), .a_o(ext_addr_o), .a_oe(ext_addr_oe),
    .a_keep(addr_keep_oe), .d_o(ext_data_o), .d_oe(ext_data_oe), .d_keep(data_keep_oe),
    .a_pin(ext_addr_i), .d_pin(ext_data_i));
  // Wait n edges, then step just past the edge where inputs change.
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Present one access request and hold it.
  task automatic put(input xbus_space_e sp, input logic wr, input logic [22:0] a,
                     input logic [15:0] d);
    req = '{1'b1, sp, wr, a, d};
  endtask
  task automatic idle();
    req = '0;
  endtask
  // Compare one value and count the comparison.
  task automatic check(input logic [22:0] seen, input logic [22:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Program write, then release with the data keeper on.
  task automatic t_write();
    put(XBUS_SP_PROG, 1'b1, 23'h5a3c96, 16'hc3e1);
    cyc(2);
    check(ext_addr_o, 23'h5a3c96);
    check(ext_addr_oe, 23'h7fffff);
    check(23'(ext_data_o), 23'h00c3e1);
    check(23'(ext_data_oe), 23'h00ffff);
    idle();
    cyc(2);
    check(23'(ext_data_oe), 23'h0);
    check(23'(data_keep_oe), 23'h00ffff);
    check(ext_addr_o, 23'h5a3c96);
    $display("write test done");
  endtask
  // Back-to-back reads from data and I/O space: upper lines stay zero.
  task automatic t_read();
    logic [15:0] lo;
    sel = 1'b1;
    for (int i = 0; i < 2; i++) begin
      lo = 16'h1234 + 16'(i);
      put(i == 0 ? XBUS_SP_DATA : XBUS_SP_IO, 1'b0, {7'h7f, lo}, 16'h0);
      cyc(6);
      check(ext_addr_o, {7'h00, lo});
      check(23'(ext_data_oe), 23'h0);
      check(23'(rdata_r), 23'(lo ^ 16'ha5c3));
    end
    sel = 1'b0;
    idle();
    cyc(2);
    $display("read test done");
  endtask
  // Global float during a write: everything floats, the keepers hold.
  task automatic t_float();
    put(XBUS_SP_PROG, 1'b1, 23'h012345, 16'h0f0f);
    cyc(2);
    float_n = 1'b0;
    cyc(5);
    check(ext_addr_oe, 23'h0);
    check(23'(ext_data_oe), 23'h0);
    check(addr_keep_oe, 23'h7fffff);
    check(ext_addr_i, 23'h012345);
    check(23'(ext_data_i), 23'h000f0f);
    float_n = 1'b1;
    idle();
    cyc(5);
    $display("float test done");
  endtask
  // Hold mode during a write, then return to driving.
  task automatic t_hold();
    put(XBUS_SP_PROG, 1'b1, 23'h400001, 16'h8001);
    hold_req = 1'b1;
    cyc(5);
    check(23'(hold_ack_r), 23'h1);
    check(ext_addr_oe, 23'h0);
    check(23'(ext_data_oe), 23'h0);
    hold_req = 1'b0;
    cyc(5);
    check(ext_addr_oe, 23'h7fffff);
    idle();
    cyc(2);
    $display("hold test done");
  endtask
  // Chip reset floats the data bus even with a write held.
  task automatic t_rst();
    put(XBUS_SP_DATA, 1'b1, 23'h000077, 16'h7777);
    chip_reset_n = 1'b0;
    cyc(5);
    check(23'(ext_data_oe), 23'h0);
    chip_reset_n = 1'b1;
    cyc(5);
    check(23'(ext_data_oe), 23'h00ffff);
    idle();
    cyc(2);
    $display("chip reset test done");
  endtask
  // With the keeper switched off nothing holds the released data lines.
  task automatic t_nohold();
    data_hold_en = 1'b0;
    put(XBUS_SP_IO, 1'b1, 23'h000aa5, 16'h5aa5);
    cyc(2);
    idle();
    cyc(2);
    check(23'(data_keep_oe), 23'h0);
    data_hold_en = 1'b1;
    $display("keeper off test done");
  endtask
  // Clock enable low freezes every register; a no-space access leaves the address.
  task automatic t_freeze();
    ce = 1'b0;
    put(XBUS_SP_PROG, 1'b1, 23'h2468ac, 16'h1357);
    cyc(3);
    check(ext_addr_o, 23'h000aa5);
    check(23'(ext_data_oe), 23'h0);
    ce = 1'b1;
    cyc(1);
    check(ext_addr_o, 23'h2468ac);
    check(23'(ext_data_o), 23'h001357);
    check(23'(ext_data_oe), 23'h00ffff);
    put(XBUS_SP_NONE, 1'b0, 23'h7fffff, 16'h0);
    cyc(2);
    check(ext_addr_o, 23'h2468ac);
    check(23'(ext_data_oe), 23'h0);
    idle();
    cyc(1);
    $display("freeze test done");
  endtask
  // Print the counts and the verdict, then stop.
  task automatic conclude();
    $display("checks %0d, mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Cut a hang short; the whole run needs well under this many cycles.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      conclude();
    end
  end
  initial begin
    cyc(3);
    sys_rst = 1'b0;
    cyc(1);
    t_write();
    t_read();
    t_float();
    t_hold();
    t_rst();
    t_nohold();
    t_freeze();
    conclude();
  end
endmodule

/* xbus_consts.svh */
// Width and reset constants for the external address/data bus block.
`ifndef XBUS_CONSTS_SVH
`define XBUS_CONSTS_SVH
`define XBUS_ADDR_W      23
`define XBUS_LOW_ADDR_W  16
`define XBUS_DATA_W      16
`define XBUS_ADDR_RST    23'h000000
`define XBUS_DATA_RST    16'h0000
`define XBUS_HOLDER_RST  1'b1
`endif

/* xbus_holder.sv */
// Bus holder model: keeps the last driven level of a floating group of lines.
`timescale 1ns/10ps
`include "xbus_consts.svh"
module xbus_holder #(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         ce,
  input  wire logic         hold_en,
  input  wire logic [W-1:0] pin_val,
  input  wire logic [W-1:0] drv_oe,
  output logic      [W-1:0] kept_val,
  output logic      [W-1:0] kept_oe
);
  // -------------------------------------------------------------
  // Holder state
  // -------------------------------------------------------------
  // Each bit follows the line on every enabled edge, whether the line is driven or floating.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      kept_val <= '0;
    end else if (ce) begin
      kept_val <= pin_val;
    end
  end

  // The holder drives only floating lines, and only when it is enabled.
  // The drivers' next enable comes in on drv_oe, so keeper and drivers swap on one edge.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      kept_oe <= '0;
    end else if (ce) begin
      kept_oe <= hold_en ? ~drv_oe : '0;
    end
  end
endmodule

/* xbus_mem_model.sv */
// Behavioural external memory and pin resolution for the external bus.
`timescale 1ns/10ps
module xbus_mem_model (
  input  wire logic        clk,
  input  wire logic        sel,
  input  wire logic [22:0] a_o,
  input  wire logic [22:0] a_oe,
  input  wire logic [22:0] a_keep,
  input  wire logic [15:0] d_o,
  input  wire logic [15:0] d_oe,
  input  wire logic [15:0] d_keep,
  output logic      [22:0] a_pin,
  output logic      [15:0] d_pin
);
  logic [22:0] a_last_r = '0;  // Last resolved address level.
  logic [15:0] d_last_r = '0;  // Last resolved data level.
  logic        mem_drv;        // Memory drives the data lines.
  logic [15:0] mem_val;        // Word the memory returns.
  // The memory answers only while the device has let go of every data line.
  assign mem_drv = sel && (d_oe == 16'h0000);
  assign mem_val = a_pin[15:0] ^ 16'ha5c3;
  // A line nobody drives or keeps shows the inverse of its last level, so a
  // missing keeper cannot pass by luck.
  assign a_pin = (a_oe & a_o) | (~a_oe & a_keep & a_last_r) | (~a_oe & ~a_keep & ~a_last_r);
  assign d_pin = mem_drv ? mem_val
               : (d_oe & d_o) | (~d_oe & d_keep & d_last_r) | (~d_oe & ~d_keep & ~d_last_r);
  // Remember the pin levels for the keeper and the float pattern.
  always @(posedge clk) begin
    a_last_r <= a_pin;
    d_last_r <= d_pin;
  end
endmodule

/* xbus_pkg.sv */
// Types shared by the external address/data bus block.
package xbus_pkg;
  // Space selected by the current external access.
  typedef enum logic [1:0] {
    XBUS_SP_NONE,
    XBUS_SP_PROG,
    XBUS_SP_DATA,
    XBUS_SP_IO
  } xbus_space_e;

  // One access request from the core.
  typedef struct packed {
    logic        valid;
    xbus_space_e space;
    logic        write;
    logic [22:0] addr;
    logic [15:0] wdata;
  } xbus_req_s;

  // Output and enable view of the address and data pin groups.
  typedef struct packed {
    logic [22:0] addr_o;
    logic [22:0] addr_oe;
    logic [15:0] data_o;
    logic [15:0] data_oe;
  } xbus_pins_s;
endpackage

/* xbus_top.sv */
// External parallel address and data bus with float control and bus holders.
// Notes on behaviour
// - Drive 23-line address bus, bit 22 MSB.
// - Low sixteen lines serve program, data, I/O.
// - Upper seven lines carry program addresses only.
// - Hold mode floats the whole address bus.
// - Global float low floats every address line.
// - Address holder keeps last level when floating.
// - 16-bit bidirectional data bus shared by spaces.
// - Drive data only on writes; float in reset/hold.
// - Global float low floats all data lines.
// - Data holder keeps last level when floating.
// - Software enables or disables data holders.
`timescale 1ns/10ps
`include "xbus_consts.svh"
module xbus_top #(
  parameter int ADDR_W = `XBUS_ADDR_W,
  parameter int DATA_W = `XBUS_DATA_W
) (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              ce,
  input  wire xbus_pkg::xbus_req_s req,
  input  wire logic              chip_reset_n,
  input  wire logic              hold_req,
  input  wire logic              float_n,
  input  wire logic              data_hold_en,
  input  wire logic [22:0]       ext_addr_i,
  input  wire logic [15:0]       ext_data_i,
  output logic      [22:0]       ext_addr_o,
  output logic      [22:0]       ext_addr_oe,
  output logic      [15:0]       ext_data_o,
  output logic      [15:0]       ext_data_oe,
  output logic      [15:0]       rdata_r,
  output logic                   hold_ack_r,
  output logic      [22:0]       addr_keep_oe,
  output logic      [15:0]       data_keep_oe
);
  import xbus_pkg::*;

  // -------------------------------------------------------------
  // Pin synchronisers
  // -------------------------------------------------------------
  logic [2:0]  pin_s1_r;       // First stage: read only by the second.
  logic [2:0]  pin_s2_r;       // Second stage: reset_n, float_n, hold.
  logic [15:0] din_s1_r;       // First stage of data input.
  logic [15:0] din_s2_r;       // Synchronised data bus level.
  logic [22:0] ain_s1_r;       // First stage of address pin level.
  logic [22:0] ain_s2_r;       // Synchronised address level for holder.

  // Asynchronous pins pass two flops before anything looks at them.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_s1_r <= 3'h6;
      pin_s2_r <= 3'h6;
      din_s1_r <= 16'h0000;
      din_s2_r <= 16'h0000;
      ain_s1_r <= 23'h000000;
      ain_s2_r <= 23'h000000;
    end else if (ce) begin
      pin_s1_r <= {chip_reset_n, float_n, hold_req};
      pin_s2_r <= pin_s1_r;
      din_s1_r <= ext_data_i;
      din_s2_r <= din_s1_r;
      ain_s1_r <= ext_addr_i;
      ain_s2_r <= ain_s1_r;
    end
  end

  logic rst_n_s;               // Synchronised chip reset, low active.
  logic flt_n_s;               // Synchronised global float, low active.
  logic hold_s;                // Synchronised bus release request.
  assign rst_n_s = pin_s2_r[2];
  assign flt_n_s = pin_s2_r[1];
  assign hold_s  = pin_s2_r[0];

  // -------------------------------------------------------------
  // Address formation
  // -------------------------------------------------------------
  // Upper lines carry bits only for program space; other spaces get zero.
  function automatic logic [22:0] form_addr(input xbus_req_s r);
    logic [22:0] a;
    a = 23'h000000;
    a[15:0] = r.addr[15:0];
    if (r.space == XBUS_SP_PROG) begin
      a[22:16] = r.addr[22:16];
    end
    return a;
  endfunction

  // Address lines float in hold or while the global float is low.
  logic addr_float;
  assign addr_float = hold_s | ~flt_n_s;

  // Data drives only for a write, never in reset, hold or global float.
  logic data_drive;
  assign data_drive = req.valid & req.write & rst_n_s & ~hold_s & flt_n_s;

  // -------------------------------------------------------------
  // Address pins
  // -------------------------------------------------------------
  // The address holds its last value between accesses.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ext_addr_o <= `XBUS_ADDR_RST;
    end else if (ce && req.valid && req.space != XBUS_SP_NONE && !addr_float) begin
      ext_addr_o <= form_addr(req);
    end
  end

  // Next enable of the address lines. The holder reads it too, because a keeper
  // fed from the registered enable would leave one cycle undriven and unkept.
  logic [22:0] addr_oe_nxt;    // Address output enables after this edge.
  assign addr_oe_nxt = addr_float ? 23'h000000 : 23'h7fffff;

  // All 23 enables drop together when the bus is released or floated.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ext_addr_oe <= 23'h000000;
    end else if (ce) begin
      ext_addr_oe <= addr_oe_nxt;
    end
  end

  // -------------------------------------------------------------
  // Data pins
  // -------------------------------------------------------------
  // Write data is launched on the same edge as its enable.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ext_data_o <= `XBUS_DATA_RST;
    end else if (ce && data_drive) begin
      ext_data_o <= req.wdata;
    end
  end

  // Next enable of the data lines, shared with the data holder for the same
  // reason as the address: the keeper must take over on the releasing edge.
  logic [15:0] data_oe_nxt;    // Data output enables after this edge.
  assign data_oe_nxt = data_drive ? 16'hffff : 16'h0000;

  // External parts must be off the bus whenever this enable is high.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ext_data_oe <= 16'h0000;
    end else if (ce) begin
      ext_data_oe <= data_oe_nxt;
    end
  end

  // Read data is captured from the synchronised bus on a read request.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_r <= 16'h0000;
    end else if (ce && req.valid && !req.write) begin
      rdata_r <= din_s2_r;
    end
  end

  // Hold acknowledge reflects the released state of the address bus.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hold_ack_r <= 1'b0;
    end else if (ce) begin
      hold_ack_r <= hold_s;
    end
  end

  // -------------------------------------------------------------
  // Bus holders
  // -------------------------------------------------------------
  // The address holder is always on; the data holder follows software.
  // Both watch the next enable, so outside sys_rst no cycle passes undriven and unkept, except on data lines while data_hold_en is low.
  xbus_holder #(.W(ADDR_W)) u_addr_hold (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .ce       (ce),
    .hold_en  (1'b1),
    .pin_val  (ain_s2_r),
    .drv_oe   (addr_oe_nxt),
    .kept_val (),
    .kept_oe  (addr_keep_oe)
  );

  xbus_holder #(.W(DATA_W)) u_data_hold (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .ce       (ce),
    .hold_en  (data_hold_en),
    .pin_val  (din_s2_r),
    .drv_oe   (data_oe_nxt),
    .kept_val (),
    .kept_oe  (data_keep_oe)
  );

  // -------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------
  property p_addr_float;
    @(posedge clk) disable iff (sys_rst)
      (ce && addr_float) |=> (ext_addr_oe == 23'h000000);
  endproperty
  a_addr_float: assert property (p_addr_float) else $error("address not floated");

  property p_float_n;
    @(posedge clk) disable iff (sys_rst)
      (ce && !flt_n_s) |=> (ext_addr_oe == 23'h000000 && ext_data_oe == 16'h0000);
  endproperty
  a_float_n: assert property (p_float_n) else $error("float low not honoured");

  property p_upper_zero;
    @(posedge clk) disable iff (sys_rst)
      (ce && req.valid && req.space == XBUS_SP_DATA && !addr_float)
        |=> (ext_addr_o[22:16] == 7'h00);
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper bits on data access");

  property p_low_addr;
    @(posedge clk) disable iff (sys_rst)
      (ce && req.valid && req.space == XBUS_SP_IO && !addr_float)
        |=> (ext_addr_o[15:0] == $past(req.addr[15:0]));
  endproperty
  a_low_addr: assert property (p_low_addr) else $error("low address wrong");

  property p_prog_addr;
    @(posedge clk) disable iff (sys_rst)
      (ce && req.valid && req.space == XBUS_SP_PROG && !addr_float)
        |=> (ext_addr_o == $past(req.addr));
  endproperty
  a_prog_addr: assert property (p_prog_addr) else $error("program address wrong");

  property p_data_reset;
    @(posedge clk) disable iff (sys_rst)
      (ce && (!rst_n_s || hold_s)) |=> (ext_data_oe == 16'h0000);
  endproperty
  a_data_reset: assert property (p_data_reset) else $error("data driven in reset/hold");

  property p_write_data;
    @(posedge clk) disable iff (sys_rst)
      (ce && data_drive) |=> (ext_data_oe == 16'hffff && ext_data_o == $past(req.wdata));
  endproperty
  a_write_data: assert property (p_write_data) else $error("write data not driven");

  property p_holder_off;
    @(posedge clk) disable iff (sys_rst)
      (ce && !data_hold_en) |=> (data_keep_oe == 16'h0000);
  endproperty
  a_holder_off: assert property (p_holder_off) else $error("data holder not off");

  property p_holder_on;
    @(posedge clk) disable iff (sys_rst)
      (ce && data_hold_en) |=> (data_keep_oe == ~ext_data_oe);
  endproperty
  a_holder_on: assert property (p_holder_on) else $error("data holder misses float");

  // -------------------------------------------------------------
  // Address, data-enable, read-path and hold checks
  // -------------------------------------------------------------
  property p_addr_drive;
    @(posedge clk) disable iff (sys_rst)
      (ce && !addr_float) |=> (ext_addr_oe == 23'h7fffff);
  endproperty
  a_addr_drive: assert property (p_addr_drive) else $error("address not driven");

  property p_addr_keep;
    @(posedge clk) disable iff (sys_rst)
      ce |=> (addr_keep_oe == ~ext_addr_oe);
  endproperty
  a_addr_keep: assert property (p_addr_keep) else $error("address keeper off");

  property p_addr_frozen;
    @(posedge clk) disable iff (sys_rst)
      (ce && addr_float) |=> $stable(ext_addr_o);
  endproperty
  a_addr_frozen: assert property (p_addr_frozen) else $error("address moved in float");

  property p_none_addr;
    @(posedge clk) disable iff (sys_rst)
      (ce && req.valid && req.space == XBUS_SP_NONE) |=> $stable(ext_addr_o);
  endproperty
  a_none_addr: assert property (p_none_addr) else $error("no-space moved addr");

  property p_io_upper;
    @(posedge clk) disable iff (sys_rst)
      (ce && req.valid && req.space == XBUS_SP_IO && !addr_float)
        |=> (ext_addr_o[22:16] == 7'h00);
  endproperty
  a_io_upper: assert property (p_io_upper) else $error("upper bits on I/O access");

  property p_data_idle;
    @(posedge clk) disable iff (sys_rst)
      (ce && !(req.valid && req.write)) |=> (ext_data_oe == 16'h0000);
  endproperty
  a_data_idle: assert property (p_data_idle) else $error("data driven, no write");

  property p_rdata;
    @(posedge clk) disable iff (sys_rst)
      (ce && req.valid && !req.write) |=> (rdata_r == $past(din_s2_r));
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data not captured");

  property p_hold_ack;
    @(posedge clk) disable iff (sys_rst)
      (ce && hold_s) |=> (hold_ack_r && ext_addr_oe == 23'h000000);
  endproperty
  a_hold_ack: assert property (p_hold_ack) else $error("hold not acknowledged");
endmodule
